// file: verilog/ccg_clock_gen.sv
// CPU clock generation: source select, CPU clock divider, machine cycle,
// peripheral clock, clock output pin and the registers that steer them.
// Assumes all inputs are synchronous to clk; slow clocks leave as enable pulses.
//
// Function
// - A machine cycle is exactly two consecutive CPU clock cycles.
// - Most instructions finish in one or two machine cycles.
// - Oscillator clock is chosen from four source kinds, feeding the divider.
// - CPU clock is the output of the divider driven by oscillator clock.
// - Peripheral clock runs at half the CPU clock rate.
// - Internal RC clock is 7.373 MHz, or 14.746 MHz with doubler.
// - Source choice comes from configuration set at programming time.
// - Crystal has low, medium and high frequency range settings.
// - Clock output allowed only when crystal is not the selected source.
// - Clock output also needs the RTC not running from the crystal.
// - Clock output driven only while its enable bit in trim is set.
// - Clock output runs at half the CPU clock frequency.
// - Extended registers sit in aux data space, reached by DPTR moves only.
// - Divider divides up to 510 and may change at any time.
// - After wake-up, crystal sources hold CPU clock 992 cycles plus delay.
// - Other sources hold CPU clock 224 oscillator cycles plus delay.
`timescale 1ns/1ps
module ccg_clock_gen
  import ccg_pkg::*;
#(
  parameter int unsigned WAKE_FIXED_CYCLES = WAKE_FIXED_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  cfgOscSel,
  input  wire logic        cfgRcDoubler,
  input  wire logic        wdtOscTick,
  input  wire logic        xtalOscTick,
  input  wire logic        extClkTick,
  input  wire logic        rtcUsesXtal,
  input  wire logic        powerDown,
  input  wire logic        wakeReq,
  input  wire logic        debugHalt,
  input  wire logic        instrLong,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWrData,
  input  wire logic        sfrWr,
  input  wire logic        sfrRd,
  output logic [7:0]       sfrRdData,
  input  wire logic [15:0] auxAddr,
  input  wire logic [7:0]  auxWrData,
  input  wire logic        auxWr,
  input  wire logic        auxRd,
  input  wire logic        auxViaDptr,
  output logic [7:0]       auxRdData,
  output logic             oscClockEn,
  output logic             cpuClockEn,
  output logic             machineCycleEn,
  output logic             instrEndEn,
  output logic             pclkEn,
  output logic [4:0]       unitPclkEn,
  output logic             cpuHold,
  output logic             crystalOutPinOut,
  output logic             crystalOutPinOe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ccg_osc_t    oscSel_r;
  ccg_osc_t    oscSel_nxt;
  logic        rcDouble_r;
  logic        rcDouble_nxt;
  logic        strapDone_r;
  logic [31:0] rcPhase_r;
  logic [31:0] rcPhase_nxt;
  logic        rcTick;
  logic [31:0] rcInc;
  logic [8:0]  divCnt_r;
  logic [8:0]  divCnt_nxt;
  logic        mcPhase_r;
  logic        mcPhase_nxt;
  logic        instrMc_r;
  logic        instrMc_nxt;
  logic        clkoutQ_r;
  logic        clkoutQ_nxt;
  logic        clkoutAllowed;
  logic        isXtal;
  logic [7:0]  trim_r;
  logic [7:0]  trim_nxt;
  logic [7:0]  clockDividerValue_r;
  logic [7:0]  clockDividerValue_nxt;
  logic [4:0]  pclkHold_r;
  logic [4:0]  pclkHold_nxt;
  logic [7:0]  sfrRdData_r;
  logic [7:0]  sfrRdData_nxt;
  logic [7:0]  auxRdData_r;
  logic [7:0]  auxRdData_nxt;
  logic        auxHit;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // True for any of the three crystal ranges.
  function automatic logic isCrystal(input ccg_osc_t sel);
    isCrystal = (sel == OSC_XTAL_LOW) || (sel == OSC_XTAL_MED) || (sel == OSC_XTAL_HIGH);
  endfunction : isCrystal

  // Divider terminal count: a nonzero value N gives a CPU clock every 2N oscillator ticks; 0 gives one every tick.
  // Comparing with greater-or-equal means a smaller N written mid-count never
  // leaves the counter stranded above the new limit.
  function automatic logic divHit(input logic [8:0] cnt, input logic [7:0] n);
    divHit = (n == 8'h00) || (cnt >= ({n, 1'b0} - 9'h001));
  endfunction : divHit

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration straps are caught on the first edge after reset release,
  // never inside the reset branch, so the flops take only constants at reset.
  always_comb begin
    oscSel_nxt   = oscSel_r;
    rcDouble_nxt = rcDouble_r;
    if (!strapDone_r) begin
      oscSel_nxt   = (cfgOscSel > 3'(OSC_EXT)) ? OSC_RC : ccg_osc_t'(cfgOscSel);
      rcDouble_nxt = cfgRcDoubler;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscSel_r    <= OSC_RC;
      rcDouble_r  <= 1'b0;
      strapDone_r <= 1'b0;
    end else begin
      oscSel_r    <= oscSel_nxt;
      rcDouble_r  <= rcDouble_nxt;
      strapDone_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal RC oscillator: the trim field nudges the nominal step up or down.
  assign rcInc = (rcDouble_r ? RC_INC2 : RC_INC)
                 + (32'(trim_r[5:0]) * RC_TRIM_STEP) - (32'(RC_TRIM_MID) * RC_TRIM_STEP);

  always_comb begin
    rcPhase_nxt = rcPhase_r + rcInc;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rcPhase_r <= 32'h0000_0000;
    end else begin
      rcPhase_r <= rcPhase_nxt;
    end
  end

  // A carry out of the accumulator is one RC oscillator period.
  assign rcTick = (rcPhase_nxt < rcPhase_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator clock select; power-down stops whichever source is chosen.
  always_comb begin
    case (oscSel_r)
      OSC_WDT:       oscClockEn = wdtOscTick;
      OSC_RC:        oscClockEn = rcTick;
      OSC_XTAL_LOW,
      OSC_XTAL_MED,
      OSC_XTAL_HIGH: oscClockEn = xtalOscTick;
      OSC_EXT:       oscClockEn = extClkTick;
      default:       oscClockEn = rcTick;
    endcase
    if (powerDown || !strapDone_r) begin
      oscClockEn = 1'b0;
    end
  end

  assign isXtal = isCrystal(oscSel_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up hold: restarted at start-up and on every wake request.
  ccg_wake_timer #(
    .FIXED_CYC (WAKE_FIXED_CYCLES)
  ) u_wake (
    .clk     (clk),
    .resetn  (resetn),
    .start   (!strapDone_r || wakeReq),
    .isXtal  (isXtal),
    .oscEn   (oscClockEn),
    .cpuHold (cpuHold)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // CPU clock divider; the divide value may be rewritten at any moment.
  assign cpuClockEn = oscClockEn && !cpuHold && divHit(divCnt_r, clockDividerValue_r);

  always_comb begin
    divCnt_nxt = divCnt_r;
    if (oscClockEn && !cpuHold) begin
      divCnt_nxt = divHit(divCnt_r, clockDividerValue_r) ? 9'h000 : divCnt_r + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 9'h000;
    end else begin
      divCnt_r <= divCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Machine cycle, peripheral clock and instruction length, all locked to
  // the CPU clock enable so no slow clock drifts against the core.
  assign machineCycleEn = cpuClockEn && mcPhase_r;
  assign pclkEn         = cpuClockEn && mcPhase_r;
  assign instrEndEn     = machineCycleEn && (instrMc_r || !instrLong);

  // Peripheral units may be held while the core is halted for debug.
  assign unitPclkEn = {HOLD_UNITS{pclkEn}} & ~(pclkHold_r & {HOLD_UNITS{debugHalt}});

  always_comb begin
    mcPhase_nxt = mcPhase_r;
    instrMc_nxt = instrMc_r;
    if (cpuClockEn) begin
      mcPhase_nxt = !mcPhase_r;
    end
    if (machineCycleEn) begin
      instrMc_nxt = instrLong && !instrMc_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mcPhase_r <= 1'b0;
      instrMc_r <= 1'b0;
    end else begin
      mcPhase_r <= mcPhase_nxt;
      instrMc_r <= instrMc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock output: the crystal owns the pin whenever the core or the RTC uses it.
  assign clkoutAllowed = !isXtal
                         && !rtcUsesXtal
                         && trim_r[TRIM_CLKOUT_BIT];

  always_comb begin
    clkoutQ_nxt = clkoutQ_r;
    if (!clkoutAllowed) begin
      clkoutQ_nxt = 1'b0;
    end else if (cpuClockEn) begin
      clkoutQ_nxt = !clkoutQ_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkoutQ_r <= 1'b0;
    end else begin
      clkoutQ_r <= clkoutQ_nxt;
    end
  end

  // Clearing the enable drops the pin at once, which is how software saves
  // power before Idle.
  assign crystalOutPinOut = clkoutQ_r;
  assign crystalOutPinOe  = clkoutAllowed;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes. Extended registers answer only to DPTR-based moves.
  assign auxHit = auxViaDptr && (auxAddr == XA_PCLK_HOLD);

  always_comb begin
    trim_nxt              = trim_r;
    clockDividerValue_nxt = clockDividerValue_r;
    pclkHold_nxt          = pclkHold_r;
    if (sfrWr && (sfrAddr == SA_TRIM)) begin
      trim_nxt = sfrWrData;
    end
    if (sfrWr && (sfrAddr == SA_CLK_DIV)) begin
      clockDividerValue_nxt = sfrWrData;
    end
    if (auxWr && auxHit) begin
      pclkHold_nxt = auxWrData[HOLD_UNITS-1:0];
    end
  end

  // Register reads: data appears one cycle after the strobe; unmapped reads 0.
  always_comb begin
    sfrRdData_nxt = sfrRdData_r;
    auxRdData_nxt = auxRdData_r;
    if (sfrRd) begin
      case (sfrAddr)
        SA_TRIM:       sfrRdData_nxt = trim_r;
        SA_CLK_DIV:    sfrRdData_nxt = clockDividerValue_r;
        SA_CLK_STATUS: sfrRdData_nxt = {1'b0, rcDouble_r, clkoutAllowed, cpuHold, 1'b0, 3'(oscSel_r)};
        default:       sfrRdData_nxt = RD_ZERO;
      endcase
    end
    if (auxRd) begin
      auxRdData_nxt = auxHit ? {3'b000, pclkHold_r} : RD_ZERO;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_r              <= TRIM_RST;
      clockDividerValue_r <= CLK_DIV_RST;
      pclkHold_r          <= PCLK_HOLD_RST;
      sfrRdData_r         <= RD_ZERO;
      auxRdData_r         <= RD_ZERO;
    end else begin
      trim_r              <= trim_nxt;
      clockDividerValue_r <= clockDividerValue_nxt;
      pclkHold_r          <= pclkHold_nxt;
      sfrRdData_r         <= sfrRdData_nxt;
      auxRdData_r         <= auxRdData_nxt;
    end
  end

  assign sfrRdData = sfrRdData_r;
  assign auxRdData = auxRdData_r;

endmodule : ccg_clock_gen

// file: verilog/ccg_pkg.sv
// Shared constants and types for the CPU clock generation block.
// Assumes a single 100 MHz system clock; every slower clock is an enable pulse.
package ccg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source choices, fixed by configuration straps at start-up.
  typedef enum logic [2:0] {
    OSC_WDT,
    OSC_RC,
    OSC_XTAL_LOW,
    OSC_XTAL_MED,
    OSC_XTAL_HIGH,
    OSC_EXT
  } ccg_osc_t;

  // Wake-up timer states.
  typedef enum logic [1:0] {
    WK_OSC,
    WK_FIXED,
    WK_RUN
  } ccg_wake_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned CLK_FREQ_KHZ   = 100000;
  localparam int unsigned WAKE_FIXED_NS  = 60000;  // Least fixed wake-up delay.
  localparam int unsigned WAKE_FIXED_CYC = (WAKE_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  WAKE_XTAL_OSC  = 10'h3E0;  // 992 oscillator cycles.
  localparam logic [9:0]  WAKE_OTHER_OSC = 10'h0E0;  // 224 oscillator cycles.

  // Internal RC oscillator, modelled as a phase accumulator on the system clock.
  localparam int unsigned RC_FREQ_KHZ    = 7373;
  localparam int unsigned RC_FREQ2_KHZ   = 14746;
  localparam logic [31:0] RC_INC         = 32'((64'(RC_FREQ_KHZ) << 32) / CLK_FREQ_KHZ);
  localparam logic [31:0] RC_INC2        = 32'((64'(RC_FREQ2_KHZ) << 32) / CLK_FREQ_KHZ);
  localparam logic [31:0] RC_TRIM_STEP   = 32'h0001_0000;
  localparam logic [5:0]  RC_TRIM_MID    = 6'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [15:0] XA_PCLK_HOLD   = 16'hFFD0;
  localparam logic [7:0]  SA_TRIM        = 8'h96;
  localparam logic [7:0]  SA_CLK_DIV     = 8'h95;
  localparam logic [7:0]  SA_CLK_STATUS  = 8'h97;

  localparam logic [7:0]  TRIM_RST       = 8'h20;  // Stand-in for the factory trim value.
  localparam logic [7:0]  CLK_DIV_RST    = 8'h00;
  localparam logic [4:0]  PCLK_HOLD_RST  = 5'h00;
  localparam logic [7:0]  RD_ZERO        = 8'h00;

  localparam int unsigned TRIM_CLKOUT_BIT = 6;
  localparam int unsigned TRIM_RCSEL_BIT  = 7;
  localparam int unsigned HOLD_UNITS      = 5;  // RTC, CCU, WDT, T1, T0 from bit 4 down.

endpackage : ccg_pkg

// file: verilog/ccg_wake_timer.sv
// Wake-up timer: holds the CPU clock until the oscillator has settled.
// Counts oscillator enable pulses, then a fixed stretch of system clocks.
`timescale 1ns/1ps
module ccg_wake_timer
  import ccg_pkg::*;
#(
  parameter int unsigned FIXED_CYC = WAKE_FIXED_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic isXtal,
  input  wire logic oscEn,
  output logic      cpuHold
);

  ccg_wake_t   state_r;
  ccg_wake_t   state_nxt;
  logic [9:0]  oscCnt_r;
  logic [9:0]  oscCnt_nxt;
  logic [15:0] fixCnt_r;
  logic [15:0] fixCnt_nxt;
  logic [9:0]  oscTarget;

  ////////////////////////////////////////////////////////////////////////////////
  // Crystals need the longer settle count; every other source the short one.
  assign oscTarget = isXtal ? WAKE_XTAL_OSC : WAKE_OTHER_OSC;

  // Next state: a start request always restarts the whole delay.
  always_comb begin
    state_nxt  = state_r;
    oscCnt_nxt = oscCnt_r;
    fixCnt_nxt = fixCnt_r;
    case (state_r)
      WK_OSC: begin
        if (oscEn) begin
          oscCnt_nxt = oscCnt_r + 10'h001;
          if (oscCnt_r + 10'h001 == oscTarget) begin
            state_nxt  = WK_FIXED;
            fixCnt_nxt = 16'h0000;
          end
        end
      end
      WK_FIXED: begin
        fixCnt_nxt = fixCnt_r + 16'h0001;
        if (fixCnt_r + 16'h0001 == 16'(FIXED_CYC)) begin
          state_nxt = WK_RUN;
        end
      end
      WK_RUN: begin
        state_nxt = WK_RUN;
      end
      default: begin
        state_nxt = WK_OSC;
      end
    endcase
    if (start) begin
      state_nxt  = WK_OSC;
      oscCnt_nxt = 10'h000;
      fixCnt_nxt = 16'h0000;
    end
  end

  // Registers of the timer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= WK_OSC;
      oscCnt_r <= 10'h000;
      fixCnt_r <= 16'h0000;
    end else begin
      state_r  <= state_nxt;
      oscCnt_r <= oscCnt_nxt;
      fixCnt_r <= fixCnt_nxt;
    end
  end

  assign cpuHold = (state_r != WK_RUN);

endmodule : ccg_wake_timer

// file: dv/ccg_osc_model.sv
// Free-running oscillator sources seen by the clock generation block.
// Assumes one tick pulse per source period; crystal and watchdog never stop.
`timescale 1ns/1ps
module ccg_osc_model #(
  parameter int WDT_P  = 8,
  parameter int XTAL_P = 3,
  parameter int EXT_P  = 5
) (
  input  wire logic clk,
  output logic      wdtOscTick,
  output logic      xtalOscTick,
  output logic      extClkTick
);
  int cnt = 0;
  // Each source pulses once per period, launched just after the edge.
  always @(posedge clk) begin
    cnt         <= cnt + 1;
    wdtOscTick  <= (cnt % WDT_P) == 0;
    xtalOscTick <= (cnt % XTAL_P) == 0;
    extClkTick  <= (cnt % EXT_P) == 0;
  end
  initial begin
    wdtOscTick  = 1'b0;
    xtalOscTick = 1'b0;
    extClkTick  = 1'b0;
  end
endmodule : ccg_osc_model

// file: dv/ccg_clock_gen_chk.sv
// Timing checker for ccg_clock_gen, attached by bind.
// Assumes the source straps only change while reset is asserted.
`timescale 1ns/1ps
module ccg_clock_gen_chk
  import ccg_pkg::*;
#(
  parameter int unsigned WAKE_FIXED_CYCLES = WAKE_FIXED_CYC
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [2:0] cfgOscSel,
  input wire logic       rtcUsesXtal,
  input wire logic       auxRd,
  input wire logic       auxViaDptr,
  input wire logic [7:0] auxRdData,
  input wire logic       oscClockEn,
  input wire logic       cpuClockEn,
  input wire logic       machineCycleEn,
  input wire logic       instrEndEn,
  input wire logic       pclkEn,
  input wire logic       cpuHold,
  input wire logic       crystalOutPinOut,
  input wire logic       crystalOutPinOe
);
  logic [1:0] cpuSinceMc_r;
  logic [1:0] cpuSinceMc_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // CPU ticks since the last machine cycle; a lost phase shows up here.
  always_comb begin
    cpuSinceMc_nxt = cpuSinceMc_r;
    if (machineCycleEn) cpuSinceMc_nxt = 2'h0;
    else if (cpuClockEn) cpuSinceMc_nxt = cpuSinceMc_r + 2'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cpuSinceMc_r <= 2'h0;
    else cpuSinceMc_r <= cpuSinceMc_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_cpu_osc; cpuClockEn |-> oscClockEn; endproperty
  a_cpu_osc: assert property (p_cpu_osc) else $error("cpu tick without osc tick");
  property p_hold; cpuHold |-> !cpuClockEn; endproperty
  a_hold: assert property (p_hold) else $error("cpu tick during wake hold");
  property p_mc; cpuClockEn |-> (machineCycleEn == (cpuSinceMc_r == 2'h1)); endproperty
  a_mc: assert property (p_mc) else $error("machine cycle not every second cpu tick");
  property p_pclk; pclkEn == machineCycleEn; endproperty
  a_pclk: assert property (p_pclk) else $error("peripheral tick not at half cpu rate");
  property p_ie; instrEndEn |-> machineCycleEn; endproperty
  a_ie: assert property (p_ie) else $error("instruction end off machine cycle");
  property p_oe_rtc; crystalOutPinOe |-> !rtcUsesXtal; endproperty
  a_oe_rtc: assert property (p_oe_rtc) else $error("clock out while rtc on crystal");
  property p_oe_src; crystalOutPinOe |-> !(cfgOscSel inside {3'h2, 3'h3, 3'h4}); endproperty
  a_oe_src: assert property (p_oe_src) else $error("clock out with crystal source");
  property p_pin_low; !crystalOutPinOe |=> !crystalOutPinOut; endproperty
  a_pin_low: assert property (p_pin_low) else $error("clock out pin active while disabled");
  property p_toggle; crystalOutPinOe && cpuClockEn |=> crystalOutPinOut != $past(crystalOutPinOut); endproperty
  a_toggle: assert property (p_toggle) else $error("clock out missed a toggle");
  property p_steady; crystalOutPinOe && !cpuClockEn |=> $stable(crystalOutPinOut); endproperty
  a_steady: assert property (p_steady) else $error("clock out moved off cpu tick");
  property p_aux; auxRd && !auxViaDptr |=> auxRdData == 8'h00; endproperty
  a_aux: assert property (p_aux) else $error("aux read outside pointer move answered");
  c_mc: cover property (machineCycleEn && instrEndEn);
  c_wake: cover property ($fell(cpuHold));
  c_pin: cover property (crystalOutPinOe && cpuClockEn);
endmodule : ccg_clock_gen_chk
bind ccg_clock_gen ccg_clock_gen_chk #(.WAKE_FIXED_CYCLES(WAKE_FIXED_CYCLES)) u_chk (
  .clk(clk), .resetn(resetn), .cfgOscSel(cfgOscSel), .rtcUsesXtal(rtcUsesXtal), .auxRd(auxRd),
  .auxViaDptr(auxViaDptr), .auxRdData(auxRdData), .oscClockEn(oscClockEn), .cpuClockEn(cpuClockEn),
  .machineCycleEn(machineCycleEn), .instrEndEn(instrEndEn), .pclkEn(pclkEn), .cpuHold(cpuHold),
  .crystalOutPinOut(crystalOutPinOut), .crystalOutPinOe(crystalOutPinOe));

// file: dv/tb_top.sv
// Self-checking bench for ccg_clock_gen with a free-running oscillator model.
// Assumes a 100 MHz clock and a shortened fixed wake-up stretch.
`timescale 1ns/1ps
module tb_top;
  import ccg_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, cfgRcDoubler = 1'b0, rtcUsesXtal = 1'b0, powerDown = 1'b0;
  logic wakeReq = 1'b0, debugHalt = 1'b0, instrLong = 1'b0, sfrWr = 1'b0, sfrRd = 1'b0;
  logic auxWr = 1'b0, auxRd = 1'b0, auxViaDptr = 1'b1;
  logic [2:0] cfgOscSel = 3'h0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, auxWrData = 8'h00, sfrRdData, auxRdData;
  logic [15:0] auxAddr = 16'h0000;
  logic wdtOscTick, xtalOscTick, extClkTick, oscClockEn, cpuClockEn, machineCycleEn;
  logic instrEndEn, pclkEn, cpuHold, crystalOutPinOut, crystalOutPinOe;
  logic [4:0] unitPclkEn;
  int err_count = 0, n_compared = 0, n;
  // Strap 6 stands for the unused codes, which the block folds onto the RC source.
  int srcTab[8] = '{0, 1, 1, 6, 2, 3, 4, 5};
  logic dblTab[8] = '{0, 0, 1, 0, 0, 0, 0, 0};
  logic isX;
  ccg_osc_model u_osc (.clk(clk), .wdtOscTick(wdtOscTick), .xtalOscTick(xtalOscTick), .extClkTick(extClkTick));
  ccg_clock_gen #(.WAKE_FIXED_CYCLES(20)) DUT (
    .clk(clk), .resetn(resetn), .cfgOscSel(cfgOscSel), .cfgRcDoubler(cfgRcDoubler),
    .wdtOscTick(wdtOscTick), .xtalOscTick(xtalOscTick), .extClkTick(extClkTick),
    .rtcUsesXtal(rtcUsesXtal), .powerDown(powerDown), .wakeReq(wakeReq), .debugHalt(debugHalt),
    .instrLong(instrLong), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrRdData(sfrRdData), .auxAddr(auxAddr), .auxWrData(auxWrData), .auxWr(auxWr), .auxRd(auxRd),
    .auxViaDptr(auxViaDptr), .auxRdData(auxRdData), .oscClockEn(oscClockEn), .cpuClockEn(cpuClockEn),
    .machineCycleEn(machineCycleEn), .instrEndEn(instrEndEn), .pclkEn(pclkEn), .unitPclkEn(unitPclkEn),
    .cpuHold(cpuHold), .crystalOutPinOut(crystalOutPinOut), .crystalOutPinOe(crystalOutPinOe));
  // Free-running 100 MHz system clock.
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // One register access; the strobe stands for exactly one taken edge.
  task automatic acc(input logic aux, input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    sfrAddr <= a[7:0]; auxAddr <= a; sfrWrData <= d; auxWrData <= d;
    sfrWr <= wr & !aux; sfrRd <= !wr & !aux; auxWr <= wr & aux; auxRd <= !wr & aux;
    @(posedge clk);
    {sfrWr, sfrRd, auxWr, auxRd} <= 4'h0;
    #1 q = aux ? auxRdData : sfrRdData;
  endtask : acc
  task automatic wr(input logic aux, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(aux, 1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input logic aux, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(aux, 1'b0, a, 8'h00, q);
    check(q, e);
  endtask : rdchk
  function automatic logic pick(input int s);
    case (s)
      0: return oscClockEn;
      1: return cpuClockEn;
      2: return machineCycleEn;
      default: return instrEndEn;
    endcase
  endfunction : pick
  // Counts base pulses from one trigger pulse to the next, bounded.
  task automatic span(input int b, input int t, output int c);
    int k;
    c = 0;
    for (k = 0; k < 6000; k++) begin @(posedge clk); #1; if (pick(t)) break; end
    if (k == 6000) begin err_count++; complete_run(); end
    for (k = 0; k < 6000; k++) begin @(posedge clk); #1; c += pick(b); if (pick(t)) break; end
    if (k == 6000) begin err_count++; complete_run(); end
  endtask : span
  task automatic count(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin @(posedge clk); #1; c += oscClockEn; end
  endtask : count
  // Oscillator ticks seen while the wake-up hold stands.
  task automatic wait_hold(output int c);
    int k;
    c = 0;
    for (k = 0; k < 20000; k++) begin @(posedge clk); #1; if (!cpuHold) break; c += oscClockEn; end
    if (k == 20000) begin err_count++; complete_run(); end
  endtask : wait_hold
  task automatic boot(input int s, input logic d);
    @(posedge clk);
    resetn <= 1'b0; cfgOscSel <= 3'(s); cfgRcDoubler <= d;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
  endtask : boot
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: every source strap, then divider, pairing, hold register and wake.
  initial begin
    for (int i = 0; i < 8; i++) begin
      boot(srcTab[i], dblTab[i]);
      isX = srcTab[i] inside {2, 3, 4};
      wait_hold(n);
      check(n >= (isX ? 992 : 224) && n <= (isX ? 999 : 231), 1);
      rdchk(0, SA_TRIM, TRIM_RST);
      rdchk(0, SA_CLK_STATUS, {1'b0, dblTab[i], 3'h0, ((srcTab[i] > 5) ? 3'h1 : 3'(srcTab[i]))});
      if (srcTab[i] inside {1, 6}) begin
        count(1000, n);
        check(n >= (dblTab[i] ? 147 : 73) && n <= (dblTab[i] ? 148 : 74), 1);
      end
      wr(0, SA_TRIM, 8'h60);
      check(crystalOutPinOe, !isX);
      rtcUsesXtal <= 1'b1;
      @(posedge clk); #1 check(crystalOutPinOe, 1'b0);
      rtcUsesXtal <= 1'b0;
      wr(0, SA_TRIM, 8'h20);
      check(crystalOutPinOe, 1'b0);
      $display("test source %0d done", i);
    end
    foreach (srcTab[j]) if (j < 3) begin
      n = (j == 0) ? 0 : (j == 1) ? 3 : 255;
      wr(0, SA_CLK_DIV, 8'(n));
      rdchk(0, SA_CLK_DIV, 8'(n));
      span(0, 1, n);
      span(0, 1, n);
      check(n, (j == 0) ? 1 : (j == 1) ? 6 : 510);
    end
    wr(0, SA_CLK_DIV, 8'h00);
    span(1, 2, n);
    check(n, 2);
    for (int l = 0; l < 2; l++) begin
      instrLong <= l[0];
      span(2, 3, n);
      span(2, 3, n);
      check(n, l + 1);
    end
    // Clock out must flip on the edge after each CPU tick, so it runs at half the CPU rate.
    wr(0, SA_TRIM, 8'h60);
    span(1, 1, n);
    isX = crystalOutPinOut;
    @(posedge clk); #1 check(crystalOutPinOut, !isX);
    span(1, 1, n);
    isX = crystalOutPinOut;
    @(posedge clk); #1 check(crystalOutPinOut, !isX);
    wr(0, SA_TRIM, 8'h20);
    @(posedge clk); #1 check(crystalOutPinOut, 1'b0);
    $display("test divider done");
    rdchk(0, 16'h0080, RD_ZERO);
    auxViaDptr <= 1'b0;
    wr(1, XA_PCLK_HOLD, 8'hFF);
    rdchk(1, XA_PCLK_HOLD, RD_ZERO);
    auxViaDptr <= 1'b1;
    rdchk(1, XA_PCLK_HOLD, RD_ZERO);
    wr(1, XA_PCLK_HOLD, 8'hFF);
    rdchk(1, XA_PCLK_HOLD, 8'h1F);
    rdchk(1, 16'hFFD1, RD_ZERO);
    wr(1, XA_PCLK_HOLD, 8'h05);
    debugHalt <= 1'b1;
    span(2, 2, n);
    check(unitPclkEn, 5'h1A);
    debugHalt <= 1'b0;
    span(2, 2, n);
    check(unitPclkEn, 5'h1F);
    powerDown <= 1'b1;
    @(posedge clk);
    count(100, n);
    check(n, 0);
    powerDown <= 1'b0;
    wakeReq <= 1'b1;
    @(posedge clk) wakeReq <= 1'b0;
    @(posedge clk); #1 check(cpuHold, 1'b1);
    wait_hold(n);
    check(n >= 222 && n <= 231, 1);
    $display("test registers and wake done");
    complete_run();
  end
endmodule : tb_top
